//--- shared/irq_regs_pkg.sv
// Function
// - upper disable word bits 13..0 map interrupts 77..64; bits 31..14 read zero
// - writing one to a disable bit clears that interrupt's enable state
// - writing zero to disable or pend bits leaves the state unchanged
// - reading a disable word returns the live enable state per interrupt
// - lower pend word bits 31..0 map interrupts 31..0
// - writing one to a pend bit forces that interrupt pending
// - pend write has no effect when already pending or disabled
// - reading a pend word returns the live pending state per interrupt
// - writing one to a clear-pend bit clears that pending bit, unless the enabled line's source requests in the same cycle
// - lower disable word covers interrupts 31..0 the same way
// - middle pend word covers interrupts 63..32 the same way
package irq_regs_pkg;

	// ==========================================================
	// sizes
	localparam int IRQ_COUNT = 78;
	localparam int DATA_W    = 32;
	localparam int WORDS     = 3;
	localparam int PAD_W     = DATA_W * WORDS;
	localparam int ADR_W     = 8;

	// ==========================================================
	// byte offsets of the first word of each group
	localparam logic [7:0] OFF_EN_SET   = 8'h00;
	localparam logic [7:0] OFF_DISABLE  = 8'h10;
	localparam logic [7:0] OFF_PEND_SET = 8'h20;
	localparam logic [7:0] OFF_PEND_CLR = 8'h30;
	localparam logic [7:0] OFF_EV_STAT  = 8'h40;
	localparam logic [7:0] OFF_EV_CLR   = 8'h44;
	localparam logic [7:0] OFF_EV_EN    = 8'h48;

	// ==========================================================
	// event status layout
	localparam int EV_W        = 3;
	localparam int EV_IGNORED  = 0;
	localparam int EV_PENDED   = 1;
	localparam int EV_DISABLED = 2;

	// ==========================================================
	// reset values
	localparam logic [EV_W-1:0]   EV_RESET   = 3'h0;
	localparam logic [DATA_W-1:0] WORD_RESET = 32'h0000_0000;

endpackage

//--- shared/irq_state_if.sv
interface irq_state_if
#(
	parameter int N = 78
);
	logic [N-1:0] set_en;
	logic [N-1:0] clr_en;
	logic [N-1:0] set_pend;
	logic [N-1:0] clr_pend;
	logic [N-1:0] src;
	logic [N-1:0] en;
	logic [N-1:0] pend;

	modport ctrl
	(
		output set_en,
		output clr_en,
		output set_pend,
		output clr_pend,
		output src,
		input  en,
		input  pend
	);

	modport bank
	(
		input  set_en,
		input  clr_en,
		input  set_pend,
		input  clr_pend,
		input  src,
		output en,
		output pend
	);
endinterface

//--- rtl/irq_state_bank.sv
module irq_state_bank
#(
	parameter int N = 78
)
(
	input  wire logic clk_sys_i,
	input  wire logic rst_i,
	irq_state_if.bank bs
);

	typedef struct packed
	{
		logic [N-1:0] en;
		logic [N-1:0] pend;
	} bank_type;

	bank_type st_q;
	bank_type st_d;

	// ==========================================================
	// shared enable and pending flops
	always_comb
	begin
		st_d = st_q;
		// both views drive the same flop; a set in the same cycle wins
		st_d.en = (st_q.en & ~bs.clr_en) | bs.set_en;
		// gated by the current enable, so a disabled line never pends
		st_d.pend = (st_q.pend & ~bs.clr_pend) | ((bs.set_pend | bs.src) & st_q.en);
	end

	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign bs.en   = st_q.en;
	assign bs.pend = st_q.pend;

	// ==========================================================
	// checks
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (rst_i);

	a_disable_clears_en: assert property ((bs.clr_en != '0) |=> ((bs.en & $past(bs.clr_en)) == '0))
		else $error("disable write left an enable set");
	a_zero_keeps_en: assert property ((bs.clr_en == '0 && bs.set_en == '0) |=> (bs.en == $past(bs.en)))
		else $error("enable changed without a write");
	a_pend_forced: assert property ((bs.set_pend & bs.en) != '0 && bs.clr_pend == '0
		|=> ((bs.pend & $past(bs.set_pend) & $past(bs.en)) == ($past(bs.set_pend) & $past(bs.en))))
		else $error("pend write did not pend an enabled line");
	a_no_pend_disabled: assert property ((bs.pend & ~$past(bs.pend) & ~$past(bs.en)) == '0)
		else $error("disabled line became pending");
	a_clear_pend: assert property ((bs.clr_pend != '0 && bs.src == '0)
		|=> ((bs.pend & $past(bs.clr_pend)) == '0))
		else $error("clear-pend write left a pending bit");
endmodule

//--- rtl/irq_disable_and_pend_regs.sv
module irq_disable_and_pend_regs
#(
	parameter int N = irq_regs_pkg::IRQ_COUNT
)
(
	input  wire logic                              clk_sys_i,
	input  wire logic                              rst_i,
	input  wire logic                              wb_cyc_i,
	input  wire logic                              wb_stb_i,
	input  wire logic                              wb_we_i,
	input  wire logic [irq_regs_pkg::ADR_W-1:0]    wb_adr_i,
	input  wire logic [3:0]                        wb_sel_i,
	input  wire logic [irq_regs_pkg::DATA_W-1:0]   wb_dat_i,
	output logic      [irq_regs_pkg::DATA_W-1:0]   wb_dat_o,
	output logic                                   wb_ack_o,
	input  wire logic [N-1:0]                      irq_src_i,
	output logic      [N-1:0]                      irq_enable_o,
	output logic      [N-1:0]                      irq_pending_o,
	output logic                                   irq_o
);

	localparam int PW = irq_regs_pkg::PAD_W;
	localparam int DW = irq_regs_pkg::DATA_W;
	localparam int EW = irq_regs_pkg::EV_W;

	typedef struct packed
	{
		logic          ack;
		logic [DW-1:0] dat;
		logic [EW-1:0] status;
		logic [EW-1:0] ev_en;
		logic          irq;
	} regs_type;

	regs_type r_q;
	regs_type r_d;

	irq_state_if #(.N(N)) st_if ();

	logic [3:0]    grp;
	logic [1:0]    wsel;
	logic          word_ok;
	logic [DW-1:0] wmask;
	logic [DW-1:0] wdat;
	logic [PW-1:0] wide;
	logic [N-1:0]  wbits;
	logic          commit;
	logic          req_new;
	logic [PW-1:0] en_pad;
	logic [PW-1:0] pend_pad;
	logic [DW-1:0] rd_word;
	logic [EW-1:0] ev;
	logic [EW-1:0] ev_clr;
	logic          is_dis;
	logic          is_en_set;
	logic          is_pset;
	logic          is_pclr;
	logic          is_evs;

	// ==========================================================
	// state bank
	irq_state_bank #(.N(N)) u_bank
	(
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.bs        (st_if.bank)
	);

	// ==========================================================
	// address decode
	always_comb
	begin
		grp       = wb_adr_i[7:4];
		wsel      = wb_adr_i[3:2];
		word_ok   = (wsel != 2'h3);
		is_en_set = (grp == irq_regs_pkg::OFF_EN_SET[7:4]) && word_ok;
		is_dis    = (grp == irq_regs_pkg::OFF_DISABLE[7:4]) && word_ok;
		is_pset   = (grp == irq_regs_pkg::OFF_PEND_SET[7:4]) && word_ok;
		is_pclr   = (grp == irq_regs_pkg::OFF_PEND_CLR[7:4]) && word_ok;
		is_evs    = (grp == irq_regs_pkg::OFF_EV_STAT[7:4]);
	end

	// ==========================================================
	// write data, byte lanes and word placement
	always_comb
	begin
		wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
		wdat  = wb_dat_i & wmask;
		// word 0 holds lines 31..0, word 1 lines 63..32, word 2 lines 77..64
		wide  = {{(PW-DW){1'b0}}, wdat} << {wsel, 5'h00};
		// bits above the last line fall off here, so upper bits 31..14 do nothing
		wbits = wide[N-1:0];
		// a write lands at the edge where the master sees ack
		commit  = wb_cyc_i && wb_stb_i && wb_we_i && r_q.ack;
		req_new = wb_cyc_i && wb_stb_i && !r_q.ack;
	end

	// ==========================================================
	// strobes toward the shared flops
	always_comb
	begin
		st_if.set_en   = (commit && is_en_set) ? wbits : '0;
		st_if.clr_en   = (commit && is_dis) ? wbits : '0;
		st_if.set_pend = (commit && is_pset) ? wbits : '0;
		st_if.clr_pend = (commit && is_pclr) ? wbits : '0;
		st_if.src      = irq_src_i;
	end

	// ==========================================================
	// read path
	always_comb
	begin
		en_pad   = {{(PW-N){1'b0}}, st_if.en};
		pend_pad = {{(PW-N){1'b0}}, st_if.pend};
		rd_word  = irq_regs_pkg::WORD_RESET;
		if (is_en_set || is_dis)
			rd_word = en_pad[{wsel, 5'h00} +: DW];
		else if (is_pset || is_pclr)
			rd_word = pend_pad[{wsel, 5'h00} +: DW];
		else if (is_evs)
		begin
			case (wb_adr_i)
				irq_regs_pkg::OFF_EV_STAT:
					rd_word = {{(DW-EW){1'b0}}, r_q.status};
				irq_regs_pkg::OFF_EV_EN:
					rd_word = {{(DW-EW){1'b0}}, r_q.ev_en};
				default:
					rd_word = irq_regs_pkg::WORD_RESET;
			endcase
		end
	end

	// ==========================================================
	// events seen by software writes
	always_comb
	begin
		ev = '0;
		ev[irq_regs_pkg::EV_IGNORED]  = commit && is_pset
			&& ((wbits & (st_if.pend | ~st_if.en)) != '0);
		ev[irq_regs_pkg::EV_PENDED]   = commit && is_pset
			&& ((wbits & ~st_if.pend & st_if.en) != '0);
		ev[irq_regs_pkg::EV_DISABLED] = commit && is_dis
			&& ((wbits & st_if.en) != '0);
		ev_clr = (commit && wb_adr_i == irq_regs_pkg::OFF_EV_CLR) ? wdat[EW-1:0] : '0;
	end

	// ==========================================================
	// register state
	always_comb
	begin
		r_d = r_q;
		r_d.ack = req_new;
		r_d.dat = req_new ? rd_word : irq_regs_pkg::WORD_RESET;
		// an event in the cycle of its clear survives
		r_d.status = (r_q.status & ~ev_clr) | ev;
		if (commit && wb_adr_i == irq_regs_pkg::OFF_EV_EN)
			r_d.ev_en = wdat[EW-1:0];
		r_d.irq = (r_d.status & r_d.ev_en) != '0;
	end

	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			r_q        <= '0;
			r_q.status <= irq_regs_pkg::EV_RESET;
			r_q.ev_en  <= irq_regs_pkg::EV_RESET;
		end
		else
			r_q <= r_d;
	end

	assign wb_ack_o      = r_q.ack;
	assign wb_dat_o      = r_q.dat;
	assign irq_o         = r_q.irq;
	assign irq_enable_o  = st_if.en;
	assign irq_pending_o = st_if.pend;

	// ==========================================================
	// checks
	logic          rd_dis_up;
	logic          rd_dis_lo;
	logic          rd_pend_lo;
	logic [DW-1:0] en_lo;
	logic [DW-1:0] pend_lo;
	logic          rd_dis_mid;
	logic          rd_pend_mid;
	logic          rd_pend_up;
	logic          rd_en_view;
	logic          rd_clr_view;
	logic          rd_any;
	logic          wr_pend_zero;
	logic          wr_ev_en;
	logic [DW-1:0] en_mid;
	logic [DW-1:0] en_up;
	logic [DW-1:0] pend_mid;
	logic [DW-1:0] pend_up;
	logic [DW-1:0] en_sel;
	logic [DW-1:0] pend_sel;

	assign rd_dis_up  = req_new && !wb_we_i && is_dis && wsel == 2'h2;
	assign rd_dis_lo  = req_new && !wb_we_i && is_dis && wsel == 2'h0;
	assign rd_pend_lo = req_new && !wb_we_i && is_pset && wsel == 2'h0;
	assign en_lo      = en_pad[DW-1:0];
	assign pend_lo    = pend_pad[DW-1:0];

	assign rd_dis_mid   = req_new && !wb_we_i && is_dis && wsel == 2'h1;
	assign rd_pend_mid  = req_new && !wb_we_i && is_pset && wsel == 2'h1;
	assign rd_pend_up   = req_new && !wb_we_i && is_pset && wsel == 2'h2;
	assign rd_en_view   = req_new && !wb_we_i && is_en_set;
	assign rd_clr_view  = req_new && !wb_we_i && is_pclr;
	assign rd_any       = req_new && !wb_we_i;
	assign wr_pend_zero = commit && is_pset && wbits == '0;
	assign wr_ev_en     = commit && wb_adr_i == irq_regs_pkg::OFF_EV_EN;
	assign en_mid       = en_pad[2*DW-1:DW];
	assign en_up        = en_pad[3*DW-1:2*DW];
	assign pend_mid     = pend_pad[2*DW-1:DW];
	assign pend_up      = pend_pad[3*DW-1:2*DW];
	// word pick written apart from the read mux, so a slip in its shift shows up
	assign en_sel       = (wsel == 2'h0) ? en_lo : ((wsel == 2'h1) ? en_mid : en_up);
	assign pend_sel     = (wsel == 2'h0) ? pend_lo : ((wsel == 2'h1) ? pend_mid : pend_up);

	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (rst_i);

	a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held more than one cycle");
	a_ack_after_req: assert property (req_new |=> wb_ack_o)
		else $error("request not answered next cycle");
	a_upper_reads_zero: assert property (rd_dis_up |=> (wb_dat_o[31:14] == 18'h0_0000))
		else $error("unused upper disable bits read nonzero");
	a_read_enable: assert property (rd_dis_lo |=> (wb_dat_o == $past(en_lo)))
		else $error("disable read differs from enable state");
	a_read_pending: assert property (rd_pend_lo |=> (wb_dat_o == $past(pend_lo)))
		else $error("pend read differs from pending state");
	a_irq_follows_ev: assert property ((ev != '0 && (ev & r_q.ev_en) != '0) |=> irq_o)
		else $error("enabled event did not raise irq");

	// ==========================================================
	// word views, events and reset
	a_upper_read_en: assert property (rd_dis_up |=> (wb_dat_o == $past(en_up)))
		else $error("upper disable read differs from enable state");
	a_mid_read_en: assert property (rd_dis_mid |=> (wb_dat_o == $past(en_mid)))
		else $error("middle disable read differs from enable state");
	a_mid_read_pend: assert property (rd_pend_mid |=> (wb_dat_o == $past(pend_mid)))
		else $error("middle pend read differs from pending state");
	a_upper_read_pend: assert property (rd_pend_up |=> (wb_dat_o == $past(pend_up)))
		else $error("upper pend read differs from pending state");
	a_en_view_same: assert property (rd_en_view |=> (wb_dat_o == $past(en_sel)))
		else $error("enable-set view differs from enable state");
	a_clr_view_same: assert property (rd_clr_view |=> (wb_dat_o == $past(pend_sel)))
		else $error("clear-pend view differs from pending state");
	a_read_no_change: assert property (rd_any |=> (irq_enable_o == $past(irq_enable_o)))
		else $error("a read changed the enable state");
	a_zero_pend_keep: assert property (wr_pend_zero
		|=> (((irq_pending_o ^ $past(irq_pending_o)) & ~$past(irq_src_i)) == '0))
		else $error("zero pend write changed a pending bit");
	a_pend_event: assert property ((commit && is_pset
		&& (wbits & irq_enable_o & ~irq_pending_o) != '0)
		|=> r_q.status[irq_regs_pkg::EV_PENDED])
		else $error("pend write that took effect left no event");
	a_disable_event: assert property ((commit && is_dis && (wbits & irq_enable_o) != '0)
		|=> r_q.status[irq_regs_pkg::EV_DISABLED])
		else $error("disable of an enabled line left no event");
	a_ignore_event: assert property ((commit && is_pset && (wbits & ~irq_enable_o) != '0)
		|=> r_q.status[irq_regs_pkg::EV_IGNORED])
		else $error("pend write to a disabled line left no event");
	a_status_sticky: assert property ((~r_q.status & $past(r_q.status) & ~$past(ev_clr)) == '0)
		else $error("event status bit fell without a clear");
	a_ev_en_write: assert property (wr_ev_en |=> (r_q.ev_en == $past(wdat[EW-1:0])))
		else $error("event enable write did not land");
	a_no_stray_ack: assert property (!req_new |=> !wb_ack_o)
		else $error("ack without a request");
	a_dat_idle_zero: assert property (!wb_ack_o |-> (wb_dat_o == '0))
		else $error("read data stands without ack");
	a_reset_quiet: assert property (disable iff (1'b0) $fell(rst_i)
		|-> (!wb_ack_o && !irq_o && irq_enable_o == '0 && irq_pending_o == '0))
		else $error("outputs not quiet after reset");

	// ==========================================================
	// per-line hold checks
	genvar gi;
	generate
		for (gi = 0; gi < N; gi++)
		begin : g_line
			a_en_holds: assert property ((irq_enable_o[gi] && !st_if.clr_en[gi])
				|=> irq_enable_o[gi])
				else $error("enable bit fell without a disable write");
			a_pend_holds: assert property ((irq_pending_o[gi] && !st_if.clr_pend[gi])
				|=> irq_pending_o[gi])
				else $error("pending bit fell without a clear");
		end
	endgenerate

	c_disable_write: cover property (commit && is_dis && wbits != '0);
	c_pend_taken: cover property (ev[irq_regs_pkg::EV_PENDED]);
	c_pend_ignored: cover property (ev[irq_regs_pkg::EV_IGNORED]);
	c_irq_raised: cover property ($rose(irq_o));
	c_src_pends: cover property ((st_if.src & st_if.en & ~st_if.pend) != '0);
endmodule

//--- test/wb_cpu_model.sv
module wb_cpu_model
(
	input  wire logic        clk_sys_i,
	output logic             wb_cyc_o,
	output logic             wb_stb_o,
	output logic             wb_we_o,
	output logic [7:0]       wb_adr_o,
	output logic [3:0]       wb_sel_o,
	output logic [31:0]      wb_dat_o,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic        wb_ack_i
);
	timeunit 1ns;
	timeprecision 1ps;

	initial
	begin
		wb_cyc_o = 1'b0;
		wb_stb_o = 1'b0;
		wb_we_o  = 1'b0;
		wb_adr_o = 8'h00;
		wb_sel_o = 4'h0;
		wb_dat_o = 32'h0000_0000;
	end

	// ==========================================================
	// one classic cycle; the caller never gets data before ack
	task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [31:0] q);
		@(posedge clk_sys_i);
		wb_cyc_o <= 1'b1;
		wb_stb_o <= 1'b1;
		wb_we_o  <= we;
		wb_adr_o <= a;
		wb_sel_o <= s;
		wb_dat_o <= d;
		// no cap here: a slave that never answers is caught by the bench watchdog
		do
		begin
			@(posedge clk_sys_i);
		end
		while (wb_ack_i !== 1'b1);
		q = wb_dat_i;
		// released lines flip so a slave leaning on stale values shows up
		wb_cyc_o <= 1'b0;
		wb_stb_o <= 1'b0;
		wb_we_o  <= ~we;
		wb_adr_o <= ~a;
		wb_sel_o <= ~s;
		wb_dat_o <= ~d;
	endtask
endmodule

//--- test/irq_disable_and_pend_regs_tb.sv
module irq_disable_and_pend_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk_sys_i;
	logic        rst_i;
	logic        cyc;
	logic        stb;
	logic        we;
	logic        ack;
	logic        irq;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [3:0]  s;
	logic [31:0] dw;
	logic [31:0] dr;
	logic [31:0] d;
	logic [31:0] q;
	logic [77:0] src;
	logic [77:0] en;
	logic [77:0] pd;
	logic [77:0] en_m;
	logic [77:0] pd_m;
	int          err_total;
	int          tests_run;

	irq_disable_and_pend_regs uut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw),
		.wb_dat_o(dr), .wb_ack_o(ack), .irq_src_i(src), .irq_enable_o(en),
		.irq_pending_o(pd), .irq_o(irq));
	wb_cpu_model cpu (.clk_sys_i(clk_sys_i), .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we),
		.wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(dw), .wb_dat_i(dr), .wb_ack_i(ack));

	// ==========================================================
	// helpers
	function automatic logic [31:0] word_of(input logic [77:0] v, input int w);
		logic [95:0] p;
		p = {18'h0, v};
		return p[32*w +: 32];
	endfunction

	function automatic logic [77:0] hit(input logic [31:0] v, input logic [3:0] m, input int w);
		logic [31:0] k;
		k = v & {{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
		return 78'(k) << (32 * w);
	endfunction

	task automatic cmp(input logic [77:0] got, input logic [77:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			err_total++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] b, input int w, input logic [31:0] v, input logic [3:0] m);
		cpu.xfer(1'b1, b + 8'(4 * w), v, m, q);
	endtask

	task automatic rd(input logic [7:0] b, input int w, input logic [31:0] e);
		cpu.xfer(1'b0, b + 8'(4 * w), 32'h0000_0000, 4'hf, q);
		cmp(78'(q), 78'(e));
	endtask

	task automatic check_state(input logic e_irq);
		@(negedge clk_sys_i);
		cmp(en, en_m);
		cmp(pd, pd_m);
		cmp(78'(irq), 78'(e_irq));
	endtask

	task automatic final_report();
		if (err_total == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// ==========================================================
	// clock, watchdog, main sequence
	initial
	begin
		clk_sys_i = 1'b0;
		forever #12.5 clk_sys_i = ~clk_sys_i;
	end

	initial
	begin
		#125000;
		err_total++;
		final_report();
	end

	initial
	begin
		rst_i = 1'b1;
		src = '0;
		en_m = '0;
		pd_m = '0;
		err_total = 0;
		tests_run = 0;
		void'($urandom(1891));
		repeat (3) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		for (int w = 0; w < 3; w++)
		begin
			rd(8'h10, w, 32'h0000_0000);
			rd(8'h20, w, 32'h0000_0000);
		end
		rd(8'h1c, 0, 32'h0000_0000);
		for (int w = 0; w < 3; w++)
		begin
			wr(8'h00, w, 32'hffff_ffff, 4'hf);
		end
		en_m = '1;
		rd(8'h18, 0, 32'h0000_3fff);
		repeat (5)
		begin
			for (int w = 0; w < 3; w++)
			begin
				d = $urandom;
				s = 4'($urandom);
				wr(8'h10, w, d, s);
				en_m &= ~hit(d, s, w);
				rd(8'h10, w, word_of(en_m, w));
				rd(8'h00, w, word_of(en_m, w));
				d = $urandom;
				s = 4'($urandom);
				wr(8'h20, w, d, s);
				pd_m |= hit(d, s, w) & en_m;
				rd(8'h20, w, word_of(pd_m, w));
				check_state(1'b0);
			end
		end
		wr(8'h18, 0, 32'h0000_0000, 4'hf);
		wr(8'h28, 0, 32'h0000_0000, 4'hf);
		for (int w = 0; w < 3; w++)
		begin
			d = $urandom;
			wr(8'h30, w, d, 4'hf);
			pd_m &= ~hit(d, 4'hf, w);
			rd(8'h20, w, word_of(pd_m, w));
			rd(8'h30, w, word_of(pd_m, w));
		end
		check_state(1'b0);
		// hardware request on a line: pends only while enabled
		@(posedge clk_sys_i);
		src <= 78'(1) << 70;
		@(posedge clk_sys_i);
		src <= '0;
		pd_m[70] = pd_m[70] | en_m[70];
		check_state(1'b0);
		// event status, mask and clear around the interrupt output
		wr(8'h44, 0, 32'h0000_0007, 4'hf);
		wr(8'h48, 0, 32'h0000_0007, 4'hf);
		rd(8'h48, 0, 32'h0000_0007);
		rd(8'h40, 0, 32'h0000_0000);
		wr(8'h00, 0, 32'h0000_0001, 4'hf);
		wr(8'h30, 0, 32'h0000_0001, 4'hf);
		wr(8'h20, 0, 32'h0000_0001, 4'hf);
		en_m[0] = 1'b1;
		pd_m[0] = 1'b1;
		rd(8'h40, 0, 32'h0000_0002);
		wr(8'h20, 0, 32'h0000_0001, 4'hf);
		wr(8'h10, 0, 32'h0000_0001, 4'hf);
		en_m[0] = 1'b0;
		check_state(1'b1);
		rd(8'h40, 0, 32'h0000_0007);
		wr(8'h48, 0, 32'h0000_0000, 4'hf);
		check_state(1'b0);
		wr(8'h48, 0, 32'h0000_0004, 4'hf);
		check_state(1'b1);
		wr(8'h44, 0, 32'h0000_0004, 4'hf);
		check_state(1'b0);
		rd(8'h40, 0, 32'h0000_0003);
		rd(8'h44, 0, 32'h0000_0000);
		final_report();
	end
endmodule
